/* File: hdl/lcdr_timing.sv */
// Purpose: common phase sequencer, quick charge window and pump clock divider
// Assumes: lcdTick is a one-cycle pulse per panel clock period
// Notes:   phaseEnd fires on the edge where the next phase begins
`timescale 1ns/1ps
`default_nettype none
module lcdr_timing (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              rst,
	// control
	input  wire logic              clear,
	input  wire logic              lcdTick,
	input  wire lcdr_pkg::lcdr_cfg_t cfg,
	// timing out
	output logic                   phaseEnd,
	output logic [2:0]             comIdx,
	output logic                   quickWin,
	output logic                   pumpLevel
);
	logic [7:0] tickCnt_q, tickCnt_d;
	logic [2:0] comIdx_q, comIdx_d;
	logic [6:0] pumpCnt_q, pumpCnt_d;
	logic       pump_q, pump_d;
	logic [6:0] pumpHalf;
	logic [2:0] pumpShift;
	logic [3:0] nCom;

	assign nCom = lcdr_pkg::comCount(cfg.dutySel);
	assign phaseEnd = lcdTick & ~clear & (tickCnt_q == lcdr_pkg::PHASE_TICKS - 8'h01);
	assign comIdx = comIdx_q;
	// code plus one periods from the phase start
	assign quickWin = ~clear & (tickCnt_q <= {5'h00, cfg.quickChargeLen}); // [R1] [R17]
	assign pumpLevel = pump_q;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		pumpShift = (cfg.pumpClkDivSel > lcdr_pkg::PUMP_SHIFT_MAX) ?
			lcdr_pkg::PUMP_SHIFT_MAX : cfg.pumpClkDivSel; // [R4]
		pumpHalf = lcdr_pkg::PUMP_HALF_MAX >> pumpShift;
		tickCnt_d = tickCnt_q;
		comIdx_d = comIdx_q;
		pumpCnt_d = pumpCnt_q;
		pump_d = pump_q;
		if (clear) begin
			tickCnt_d = 8'h00;
			comIdx_d = 3'h0;
			pumpCnt_d = 7'h00;
			pump_d = 1'b0;
		end else if (lcdTick) begin
			if (phaseEnd) begin
				tickCnt_d = 8'h00;
				comIdx_d = ({1'b0, comIdx_q} == nCom - 4'h1) ? 3'h0 : comIdx_q + 3'h1; // [R5]
			end else begin
				tickCnt_d = tickCnt_q + 8'h01;
			end
			if (pumpCnt_q >= pumpHalf - 7'h01) begin
				pumpCnt_d = 7'h00;
				pump_d = ~pump_q;
			end else begin
				pumpCnt_d = pumpCnt_q + 7'h01;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tickCnt_q <= 8'h00;
			comIdx_q <= 3'h0;
			pumpCnt_q <= 7'h00;
			pump_q <= 1'b0;
		end else begin
			tickCnt_q <= tickCnt_d;
			comIdx_q <= comIdx_d;
			pumpCnt_q <= pumpCnt_d;
			pump_q <= pump_d;
		end
	end
endmodule // lcdr_timing
`default_nettype wire

/* File: hdl/lcdr_top.sv */
// Purpose: segment LCD setup registers, internal reset and common drive control
// Assumes: panelClk and sleepMode are synchronous to mclk
// Notes:   rst is the MCU reset; while it is high every pad enable is low
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Function
// R1: quick charge length is code plus one periods
// R2: unimplemented register bits read as zero; main register bits 4, 5 and 7 read back as written
// R3: level code selects (8+code)/16 or full
// R4: pump divider 128 down to 2, 111=2
// R5: duty code picks four, six or eight commons
// R6: unused commons released to pin sharing
// R7: bias bit selects one-third or one-quarter; with C-type bias the code always uses one-third
// R8: software should pair eight commons with quarter
// R9: C-type bias enables divided-clock charge pump
// R10: third uses four levels, quarter five
// R11: internal reset is not-enable or sleep
// R12: sleep resets function, enable bit kept
// R13: outputs normal, low, or floating by state
// R14: watchdog wake reset does not float outputs
// R15: bias kind bit R-type 0, C-type 1
// R16: enable bit gates driver, clears at reset
// R17: quick charge low resistance at phase start
// R18: settings change only at phase boundaries
// R19: all control fields reset to zero
module lcdr_top (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// apb slave
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// system state
	input  wire logic        sleepMode,
	input  wire logic        wdtWakeReset,
	input  wire logic        panelClk,
	// panel drive control
	output logic [7:0]       comStrobe,
	output logic [7:0]       comOe,
	output logic [7:0]       comRelease,
	output logic             segOe,
	output logic             driveLow,
	output logic             lcdReset,
	output logic             quickCharge,
	output logic [4:0]       levelNum,
	output logic [2:0]       levelCount,
	output logic             pumpEnable,
	output logic             pumpClk
);
	// ****************************************
	// declarations
	// ****************************************
	logic [7:0]  main_q, main_d;
	logic [7:0]  qcl_q, qcl_d;
	logic [7:0]  pcd_q, pcd_d;
	logic [31:0] prdata_q, prdata_d;
	logic        pready_q, pready_d;
	logic        pslverr_q, pslverr_d;
	logic        panelPrev_q, panelPrev_d;
	lcdr_pkg::lcdr_cfg_t cfg_q, cfg_d;
	lcdr_pkg::lcdr_cfg_t liveCfg;

	logic [7:0]  comStrobe_q, comStrobe_d;
	logic [7:0]  comOe_q, comOe_d;
	logic [7:0]  comRelease_q, comRelease_d;
	logic        segOe_q, segOe_d;
	logic        driveLow_q, driveLow_d;
	logic        lcdReset_q, lcdReset_d;
	logic        quick_q, quick_d;
	logic [4:0]  levelNum_q, levelNum_d;
	logic [2:0]  levelCount_q, levelCount_d;
	logic        pumpEn_q, pumpEn_d;
	logic        pumpClk_q, pumpClk_d;

	logic        setup;
	logic        wrStrobe;
	logic        mapped;
	logic [7:0]  rdByte;
	logic [7:0]  status;
	logic        funcReset;
	logic        intReset;
	logic        lcdTick;
	logic        phaseEnd;
	logic [2:0]  comIdx;
	logic        quickWin;
	logic        pumpLevel;
	logic [3:0]  nCom;
	logic [7:0]  comUsed;
	logic [7:0]  comHit;
	logic        rselQuick;
	logic        quickMode_q, quickMode_d;

	// ****************************************
	// apb slave
	// ****************************************
	// zero-wait: data prepared in setup, pready high in the first access cycle
	assign setup = psel & ~penable;
	assign wrStrobe = psel & penable & pwrite & pready_q;
	assign status = {lcdReset_q, quick_q, pumpEn_q, comIdx, levelCount_q[1:0]};

	always_comb begin
		mapped = 1'b1;
		case (paddr)
			lcdr_pkg::OFF_MAIN: rdByte = main_q;
			lcdr_pkg::OFF_QCL:  rdByte = qcl_q & lcdr_pkg::QCL_MASK; // [R2]
			lcdr_pkg::OFF_PCD:  rdByte = pcd_q & lcdr_pkg::PCD_MASK; // [R2]
			lcdr_pkg::OFF_STAT: rdByte = status;
			default: begin
				rdByte = 8'h00;
				mapped = 1'b0;
			end
		endcase
	end

	always_comb begin
		prdata_d = 32'h0000_0000;
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		if (setup) begin
			pready_d = 1'b1;
			pslverr_d = ~mapped;
			if (!pwrite) begin
				prdata_d = {24'h00_0000, rdByte};
			end
		end
	end

	// ****************************************
	// control registers
	// ****************************************
	// enable bit is untouched by sleep; only software writes and the MCU reset change it
	always_comb begin
		main_d = main_q; // [R12]
		qcl_d = qcl_q;
		pcd_d = pcd_q;
		if (wrStrobe) begin
			case (paddr)
				lcdr_pkg::OFF_MAIN: main_d = pwdata[7:0] & lcdr_pkg::MAIN_MASK; // [R15] [R16]
				lcdr_pkg::OFF_QCL:  qcl_d = pwdata[7:0] & lcdr_pkg::QCL_MASK; // [R1] [R3]
				lcdr_pkg::OFF_PCD:  pcd_d = pwdata[7:0] & lcdr_pkg::PCD_MASK; // [R4] [R5] [R7]
				default: begin
					main_d = main_q;
				end
			endcase
		end
	end

	always_comb begin
		liveCfg.quickChargeLen = qcl_q[lcdr_pkg::QCL_LEN_LSB +: 3];
		liveCfg.topLevelCode = qcl_q[lcdr_pkg::QCL_CODE_LSB +: 4];
		liveCfg.pumpClkDivSel = pcd_q[lcdr_pkg::PCD_DIV_LSB +: 3];
		liveCfg.dutySel = pcd_q[lcdr_pkg::PCD_DUTY_LSB +: 2];
		liveCfg.quarterBias = pcd_q[lcdr_pkg::PCD_BIAS_BIT];
		liveCfg.biasKindSel = main_q[lcdr_pkg::MAIN_KIND_BIT];
	end

	// ****************************************
	// internal reset and settings shadow
	// ****************************************
	assign funcReset = ~main_q[lcdr_pkg::MAIN_EN_BIT] | sleepMode; // [R11] [R12] [R16]
	// a watchdog wake restarts the sequencer but is not the pad-floating reset
	assign intReset = funcReset | wdtWakeReset; // [R14]
	assign lcdTick = panelClk & ~panelPrev_q;
	assign panelPrev_d = panelClk;

	// while held in reset the shadow follows at once, nothing is being shown
	always_comb begin
		cfg_d = cfg_q;
		quickMode_d = quickMode_q;
		if (intReset || phaseEnd) begin
			cfg_d = liveCfg; // [R18]
			quickMode_d = rselQuick; // [R18]
		end
	end

	lcdr_timing i_lcdr_timing (
		.mclk      (mclk),
		.rst       (rst),
		.clear     (intReset),
		.lcdTick   (lcdTick),
		.cfg       (cfg_q),
		.phaseEnd  (phaseEnd),
		.comIdx    (comIdx),
		.quickWin  (quickWin),
		.pumpLevel (pumpLevel)
	);

	// ****************************************
	// common selection per pin
	// ****************************************
	assign nCom = lcdr_pkg::comCount(cfg_q.dutySel);

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_com
			assign comUsed[gi] = (4'(gi) < nCom); // [R5]
			assign comHit[gi] = comUsed[gi] & (comIdx == 3'(gi));
		end
	endgenerate

	// ****************************************
	// drive control
	// ****************************************
	// resistor mode is shadowed with the rest so a phase never mixes settings
	assign rselQuick = main_q[lcdr_pkg::MAIN_RSEL_LSB +: 3] >= lcdr_pkg::RSEL_QUICK_MIN;

	always_comb begin
		comOe_d = comUsed; // [R13]
		comRelease_d = ~comUsed; // [R6]
		comStrobe_d = intReset ? 8'h00 : comHit; // [R13]
		segOe_d = 1'b1; // [R13] [R14]
		driveLow_d = intReset; // [R13]
		lcdReset_d = funcReset; // [R11]
		quick_d = ~intReset & ~cfg_q.biasKindSel & quickMode_q & quickWin; // [R17]
		levelNum_d = cfg_q.topLevelCode[3] ? lcdr_pkg::LEVEL_FULL :
			lcdr_pkg::LEVEL_BASE + {2'b00, cfg_q.topLevelCode[2:0]}; // [R3]
		// quarter bias is only meaningful with the resistor ladder
		levelCount_d = (cfg_q.quarterBias && !cfg_q.biasKindSel) ?
			lcdr_pkg::LEVELS_QUARTER : lcdr_pkg::LEVELS_THIRD; // [R7] [R10]
		pumpEn_d = cfg_q.biasKindSel & ~intReset; // [R9] [R15]
		pumpClk_d = pumpEn_d & pumpLevel; // [R9]
	end

	// ****************************************
	// state registers
	// ****************************************
	// every control field clears on the MCU reset; pad enables low means floating
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			main_q <= lcdr_pkg::MAIN_RESET; // [R19]
			qcl_q <= lcdr_pkg::QCL_RESET; // [R19]
			pcd_q <= lcdr_pkg::PCD_RESET; // [R19]
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			panelPrev_q <= 1'b0;
			cfg_q <= '0;
			quickMode_q <= 1'b0;
			comStrobe_q <= 8'h00;
			comOe_q <= 8'h00; // [R13]
			comRelease_q <= 8'h00;
			segOe_q <= 1'b0; // [R13]
			driveLow_q <= 1'b0;
			lcdReset_q <= 1'b1;
			quick_q <= 1'b0;
			levelNum_q <= 5'h00;
			levelCount_q <= 3'h0;
			pumpEn_q <= 1'b0;
			pumpClk_q <= 1'b0;
		end else begin
			main_q <= main_d;
			qcl_q <= qcl_d;
			pcd_q <= pcd_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			panelPrev_q <= panelPrev_d;
			cfg_q <= cfg_d;
			quickMode_q <= quickMode_d;
			comStrobe_q <= comStrobe_d;
			comOe_q <= comOe_d;
			comRelease_q <= comRelease_d;
			segOe_q <= segOe_d;
			driveLow_q <= driveLow_d;
			lcdReset_q <= lcdReset_d;
			quick_q <= quick_d;
			levelNum_q <= levelNum_d;
			levelCount_q <= levelCount_d;
			pumpEn_q <= pumpEn_d;
			pumpClk_q <= pumpClk_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign comStrobe = comStrobe_q;
	assign comOe = comOe_q;
	assign comRelease = comRelease_q;
	assign segOe = segOe_q;
	assign driveLow = driveLow_q;
	assign lcdReset = lcdReset_q;
	assign quickCharge = quick_q;
	assign levelNum = levelNum_q;
	assign levelCount = levelCount_q;
	assign pumpEnable = pumpEn_q;
	assign pumpClk = pumpClk_q;
endmodule // lcdr_top
`default_nettype wire

/* File: shared/lcdr_pkg.sv */
// Purpose: shared constants and types for the segment LCD setup and reset block
// Assumes: 32-bit APB, one aligned word per 8-bit register
// Notes:   offsets of the three control words and the status word are fixed here
`default_nettype none
package lcdr_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [11:0] OFF_MAIN = 12'h000;
	localparam logic [11:0] OFF_QCL  = 12'h004;
	localparam logic [11:0] OFF_PCD  = 12'h008;
	localparam logic [11:0] OFF_STAT = 12'h00C;

	localparam logic [7:0] MAIN_RESET = 8'h00;
	localparam logic [7:0] QCL_RESET  = 8'h00;
	localparam logic [7:0] PCD_RESET  = 8'h00;
	// implemented bits for QCL and PCD, whose holes read back as zero; MAIN_MASK keeps all eight bits
	localparam logic [7:0] MAIN_MASK  = 8'hFF;
	localparam logic [7:0] QCL_MASK   = 8'hEF;
	localparam logic [7:0] PCD_MASK   = 8'hE7;

	// ****************************************
	// field positions
	// ****************************************
	localparam int MAIN_EN_BIT   = 0;
	localparam int MAIN_RSEL_LSB = 1;
	localparam int MAIN_KIND_BIT = 6;
	localparam int QCL_CODE_LSB  = 0;
	localparam int QCL_LEN_LSB   = 5;
	localparam int PCD_BIAS_BIT  = 0;
	localparam int PCD_DUTY_LSB  = 1;
	localparam int PCD_DIV_LSB   = 5;

	// ****************************************
	// timing
	// ****************************************
	// panel clock periods in one common phase
	localparam logic [7:0] PHASE_TICKS = 8'h20;
	localparam logic [6:0] PUMP_HALF_MAX = 7'h40;
	localparam logic [2:0] PUMP_SHIFT_MAX = 3'h6;
	// resistor select codes at or above this use quick charge
	localparam logic [2:0] RSEL_QUICK_MIN = 3'h3;
	localparam logic [4:0] LEVEL_BASE = 5'h08;
	localparam logic [4:0] LEVEL_FULL = 5'h10;
	localparam logic [2:0] LEVELS_THIRD   = 3'h4;
	localparam logic [2:0] LEVELS_QUARTER = 3'h5;

	typedef enum logic [1:0] {DUTY_4, DUTY_6, DUTY_8, DUTY_NONE} lcdr_duty_t;

	typedef struct packed {
		logic [2:0] quickChargeLen;
		logic [3:0] topLevelCode;
		logic [2:0] pumpClkDivSel;
		logic [1:0] dutySel;
		logic       quarterBias;
		logic       biasKindSel;
	} lcdr_cfg_t;

	function automatic logic [3:0] comCount(input logic [1:0] duty);
		case (lcdr_duty_t'(duty))
			DUTY_6:  comCount = 4'h6;
			DUTY_8:  comCount = 4'h8;
			default: comCount = 4'h4;
		endcase
	endfunction
endpackage
`default_nettype wire

/* File: test/lcdr_panel_model.sv */
// Purpose: passive glass model, records which commons were scanned
// Assumes: strobes sampled on mclk
// Notes:   glass answers nothing; it only observes
`timescale 1ns/1ps
`default_nettype none
module lcdr_panel_model (
	// drive from the block
	input wire logic       mclk,
	input wire logic       clearSeen,
	input wire logic [7:0] comStrobe,
	input wire logic [7:0] comOe,
	input wire logic       driveLow,
	// observation
	output logic [7:0]     seenMask
);
	// ****
	// scan record
	// ****
	// forced-low phases show nothing on the glass
	always_ff @(posedge mclk)
		if (clearSeen)
			seenMask <= 8'h00;
		else if (!driveLow)
			seenMask <= seenMask | (comStrobe & comOe);
endmodule // lcdr_panel_model
`default_nettype wire

/* File: test/lcdr_top_chk.sv */
// Purpose: port-level checker for lcdr_top
// Assumes: single clock domain, rst async active high
// Notes:   bound to lcdr_top at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module lcdr_top_chk (
	// clock and reset
	input wire logic        mclk,
	input wire logic        rst,
	// apb and system
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        sleepMode,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// panel drive
	input wire logic [7:0]  comStrobe,
	input wire logic [7:0]  comOe,
	input wire logic [7:0]  comRelease,
	input wire logic        segOe,
	input wire logic        driveLow,
	input wire logic        lcdReset,
	input wire logic        quickCharge,
	input wire logic [4:0]  levelNum,
	input wire logic [2:0]  levelCount,
	input wire logic        pumpEnable,
	input wire logic        pumpClk
);
	// ****
	// properties
	// ****
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	ready_after_setup_a: assert property (psel && !penable |=> pready)
		else $error("pready not one cycle after setup");
	unmapped_error_a: assert property (psel && !penable && paddr > 12'h00C |=> pslverr)
		else $error("no pslverr on unmapped address");
	idle_data_zero_a: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("prdata nonzero outside access");
	sleep_resets_a: assert property (sleepMode |=> lcdReset)
		else $error("sleep did not raise lcdReset");
	reset_drives_low_a: assert property (!$past(rst) && lcdReset |-> driveLow)
		else $error("internal reset without low drive");
	no_float_a: assert property (!$past(rst) |-> segOe)
		else $error("segments float outside rst");
	free_coms_a: assert property (!$past(rst) |-> comRelease == ~comOe)
		else $error("common release not inverse of use");
	strobe_used_a: assert property ((comStrobe & ~comOe) == 8'h00)
		else $error("strobe on unused common");
	level_legal_a: assert property (!$past(rst) |->
		levelNum inside {[5'h08:5'h10]} && levelCount inside {3'h4, 3'h5})
		else $error("level outside legal range");
	pump_gated_a: assert property (!pumpEnable ##1 !pumpEnable |-> !pumpClk)
		else $error("pump clock runs while disabled");
	cover property (pready && pslverr);
	cover property ($rose(quickCharge));
	cover property ($rose(pumpClk));
	cover property ($rose(lcdReset));
endmodule // lcdr_top_chk
bind lcdr_top lcdr_top_chk i_lcdr_top_chk (.mclk(mclk), .rst(rst), .paddr(paddr),
	.psel(psel), .penable(penable), .sleepMode(sleepMode), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .comStrobe(comStrobe), .comOe(comOe),
	.comRelease(comRelease), .segOe(segOe), .driveLow(driveLow), .lcdReset(lcdReset),
	.quickCharge(quickCharge), .levelNum(levelNum), .levelCount(levelCount),
	.pumpEnable(pumpEnable), .pumpClk(pumpClk));
`default_nettype wire

/* File: test/lcdr_top_test.sv */
// Purpose: self-checking bench for lcdr_top
// Assumes: panel clock is mclk divided by four
// Notes:   one phase is 32 ticks, 128 mclk
`timescale 1ns/1ps
`default_nettype none
module lcdr_top_test;
	// ****
	// signals
	// ****
	logic        mclk = 1'b0;
	logic        rst, psel, penable, pwrite, sleepMode, wdtWakeReset, clearSeen;
	logic        panelClk = 1'b0;
	logic [1:0]  divCnt = 2'h0;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic        pready, pslverr, e, segOe, driveLow, lcdReset, quickCharge;
	logic        pumpEnable, pumpClk;
	logic [7:0]  comStrobe, comOe, comRelease, seenMask;
	logic [4:0]  levelNum;
	logic [2:0]  levelCount;
	int          fails = 0;
	int          num_checks = 0;
	int          i, n;
	logic [7:0]  oeTab [4] = '{8'h0F, 8'h3F, 8'hFF, 8'h0F};
	logic [3:0]  lvTab [4] = '{4'h0, 4'h7, 4'h8, 4'hF};
	logic [4:0]  numTab [4] = '{5'h08, 5'h0F, 5'h10, 5'h10};
	always #25 mclk = ~mclk;
	always @(posedge mclk) begin
		divCnt <= divCnt + 2'h1;
		panelClk <= divCnt[1];
	end
	lcdr_top i_lcdr_top (.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sleepMode(sleepMode),
		.wdtWakeReset(wdtWakeReset), .panelClk(panelClk), .comStrobe(comStrobe),
		.comOe(comOe), .comRelease(comRelease), .segOe(segOe), .driveLow(driveLow),
		.lcdReset(lcdReset), .quickCharge(quickCharge), .levelNum(levelNum),
		.levelCount(levelCount), .pumpEnable(pumpEnable), .pumpClk(pumpClk));
	lcdr_panel_model i_lcdr_panel_model (.mclk(mclk), .clearSeen(clearSeen),
		.comStrobe(comStrobe), .comOe(comOe), .driveLow(driveLow), .seenMask(seenMask));
	// ****
	// tasks
	// ****
	task automatic summarize;
		$display("Checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic bound(input int k);
		if (k >= 400) begin
			fails++;
			$display("Error at %0t: wait timed out", $time);
			summarize();
		end
	endtask
	task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
		int k;
		k = 0;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h00_0000, d};
		psel <= 1'b1;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			k++;
		end while (pready !== 1'b1 && k < 400);
		bound(k);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// one idle edge so a following call never reassigns psel in this step
		@(posedge mclk);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [7:0] x);
		apb(a, 1'b0, 8'h00);
		chk(r, {24'h00_0000, x});
	endtask
	// ****
	// sequence
	// ****
	initial begin
		{rst, psel, penable, pwrite, sleepMode, wdtWakeReset, clearSeen} = 7'h41;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rdc(lcdr_pkg::OFF_QCL, 8'h00);
		rdc(lcdr_pkg::OFF_PCD, 8'h00);
		apb(12'h010, 1'b0, 8'h00);
		chk(e, 1'b1);
		apb(lcdr_pkg::OFF_QCL, 1'b1, 8'hFF);
		rdc(lcdr_pkg::OFF_QCL, 8'hEF);
		apb(lcdr_pkg::OFF_PCD, 1'b1, 8'hFF);
		rdc(lcdr_pkg::OFF_PCD, 8'hE7);
		// in internal reset the settings land at once
		for (i = 0; i < 4; i++) begin
			apb(lcdr_pkg::OFF_PCD, 1'b1, {5'h00, i[1:0], i[1] ^ i[0]});
			apb(lcdr_pkg::OFF_QCL, 1'b1, {4'h0, lvTab[i]});
			repeat (3) @(posedge mclk);
			chk(comOe, oeTab[i]);
			chk(levelNum, numTab[i]);
			chk(levelCount, (i[1] ^ i[0]) ? 3'h5 : 3'h4);
		end
		apb(lcdr_pkg::OFF_PCD, 1'b1, 8'h02);
		apb(lcdr_pkg::OFF_MAIN, 1'b1, 8'h01);
		clearSeen <= 1'b0;
		repeat (3) @(posedge mclk);
		chk({lcdReset, driveLow}, 2'b00);
		repeat (900) @(posedge mclk);
		chk(seenMask, 8'h3F);
		sleepMode <= 1'b1;
		repeat (3) @(posedge mclk);
		chk({lcdReset, driveLow}, 2'b11);
		rdc(lcdr_pkg::OFF_MAIN, 8'h01);
		sleepMode <= 1'b0;
		wdtWakeReset <= 1'b1;
		@(posedge mclk);
		wdtWakeReset <= 1'b0;
		@(posedge mclk);
		chk({segOe, comOe, lcdReset}, {1'b1, 8'h3F, 1'b0});
		apb(lcdr_pkg::OFF_QCL, 1'b1, 8'h40);
		apb(lcdr_pkg::OFF_MAIN, 1'b1, 8'h07);
		for (n = 0; quickCharge !== 1'b1 && n < 400; n++)
			@(posedge mclk);
		bound(n);
		for (n = 0; quickCharge === 1'b1 && n < 400; n++)
			@(posedge mclk);
		chk(n >= 11 && n <= 13, 1'b1);
		apb(lcdr_pkg::OFF_PCD, 1'b1, 8'hC2);
		apb(lcdr_pkg::OFF_MAIN, 1'b1, 8'h41);
		for (n = 0; pumpEnable !== 1'b1 && n < 400; n++)
			@(posedge mclk);
		bound(n);
		chk(pumpEnable, 1'b1);
		i = 0;
		for (n = 0; n < 64; n++) begin
			@(posedge mclk);
			if (pumpClk !== i[0])
				i++;
		end
		chk(i >= 15 && i <= 17, 1'b1);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		chk({segOe, comOe}, 9'h000);
		rst <= 1'b0;
		@(posedge mclk);
		rdc(lcdr_pkg::OFF_MAIN, 8'h00);
		rdc(lcdr_pkg::OFF_PCD, 8'h00);
		rdc(lcdr_pkg::OFF_STAT, 8'h80);
		summarize();
	end
endmodule // lcdr_top_test
`default_nettype wire
